/* File: rtl/edopc_pkg.sv */
// Constants and types for the page-mode memory controller
package edopc_pkg;

  // ---------------------------------------------------------------
  // Clock and device timing, nanoseconds except T_REF_MS (ms) and T_POWER_US (us)
  // ---------------------------------------------------------------
  localparam int CLK_NS      = 25;
  localparam int T_RAS_NS    = 60;
  localparam int T_RP_NS     = 40;
  localparam int T_CP_NS     = 10;
  localparam int T_CAS_NS    = 10;
  localparam int T_CSR_NS    = 10;
  localparam int T_RAC_NS    = 60;
  localparam int T_CAC_NS    = 15;
  localparam int T_AA_NS     = 30;
  localparam int T_RASP_NS   = 100000;
  localparam int T_REF_MS    = 16;
  localparam int T_POWER_US  = 200;

  // ---------------------------------------------------------------
  // Counts
  // ---------------------------------------------------------------
  localparam int ROW_W        = 10;
  localparam int ADDR_W       = 20;
  localparam int DATA_W       = 4;
  localparam int REF_ROWS     = 1024;
  localparam int WAKE_CYCLES  = 8;
  localparam int SYNC_STAGES  = 2;
  localparam int REF_LATE_MAX = 4;
  localparam int WAIT_W       = 14;

  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  function automatic int floor_cyc(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : floor_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  localparam int RAS_CYC   = ceil_cyc(T_RAS_NS);
  localparam int RP_CYC    = ceil_cyc(T_RP_NS);
  localparam int CP_CYC    = ceil_cyc(T_CP_NS);
  localparam int CSR_CYC   = ceil_cyc(T_CSR_NS);
  localparam int WR_CAS_CYC = ceil_cyc(T_CAS_NS);
  // Row strobe leads column strobe by two cycles
  localparam int RD_ACC_CYC = max2(max2(ceil_cyc(T_CAC_NS),
                                        ceil_cyc(T_AA_NS)),
                                   ceil_cyc(T_RAC_NS) - 2);
  localparam int RD_CAS_CYC = RD_ACC_CYC + SYNC_STAGES;
  localparam int RASP_CYC  = floor_cyc(T_RASP_NS);
  localparam int RASP_LIMIT = RASP_CYC - (RD_CAS_CYC + CP_CYC + 4);
  localparam int REF_TICK_CYC =
    (T_REF_MS * 1000000) / (REF_ROWS * CLK_NS);
  localparam int POWER_CYC = ceil_cyc(T_POWER_US * 1000);

  typedef enum logic [3:0] {
    S_POWER   = 4'h0,
    S_IDLE    = 4'h1,
    S_RAS     = 4'h2,
    S_COL     = 4'h3,
    S_CAS     = 4'h4,
    S_OPEN    = 4'h5,
    S_PRE     = 4'h6,
    S_REF_CAS = 4'h7,
    S_REF_RAS = 4'h8
  } edopc_state_t;

endpackage : edopc_pkg

/* File: rtl/edopc_ctrl.sv */
// Controller driving a 1M x 4 page-mode dynamic memory over its pins
// What this block does
// - Send 20-bit address as row/column halves
// - Hold row active minimum; respect precharge
// - Hold column address stable during read
// - Space page and random cycles per grade
// - Write data valid before column strobe falls
// - 1024 refreshes within every 16 ms
// - Wait 200 us, then eight row cycles
// - Repeat wake-up when refresh budget exceeded
`timescale 1ns/1ps

module edopc_ctrl
  import edopc_pkg::*;
#(
  parameter int POWER_WAIT = POWER_CYC
) (
  // Clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  // Request port
  input  wire logic                i_req_valid,
  output logic                     o_req_ready,
  input  wire logic                i_req_write,
  input  wire logic [ADDR_W-1:0]   i_req_addr,
  input  wire logic [DATA_W-1:0]   i_req_wdata,
  // Read data port
  output logic                     o_rd_valid,
  input  wire logic                i_rd_ready,
  output logic      [DATA_W-1:0]   o_rd_data,
  // Status
  output logic                     o_init_done,
  // Memory pins
  output logic      [ROW_W-1:0]    o_mux_address_pins,
  output logic                     o_row_strobe_n,
  output logic                     o_col_strobe_n,
  output logic                     o_write_strobe_n,
  output logic                     o_out_gate_n,
  input  wire logic [DATA_W-1:0]   i_nibble_data_pins,
  output logic      [DATA_W-1:0]   o_nibble_data_pins,
  output logic                     o_nibble_data_oe_n
);

  // ---------------------------------------------------------------
  // State and declarations
  // ---------------------------------------------------------------
  edopc_state_t              state;
  edopc_state_t              next_state;
  logic [WAIT_W-1:0]         wait_cnt;
  logic [WAIT_W-1:0]         next_wait;
  logic [WAIT_W-1:0]         ras_time;
  logic [9:0]                tick_cnt;
  logic [2:0]                ref_pend;
  logic [3:0]                wake_left;
  logic                      op_wr;
  logic [ADDR_W-1:0]         addr_r;
  logic [DATA_W-1:0]         din_s1;
  logic [DATA_W-1:0]         din_s2;
  logic [DATA_W-1:0]         fifo_mem [2];
  logic                      fifo_wp;
  logic                      fifo_rp;
  logic [1:0]                fifo_cnt;

  wire wait_done  = (wait_cnt == '0);
  wire ref_need   = (ref_pend != '0) || (wake_left != '0);
  wire same_row   = (i_req_addr[ADDR_W-1:ROW_W] == addr_r[ADDR_W-1:ROW_W]);
  wire fifo_room  = (fifo_cnt != 2'h2);
  wire can_start  = (state == S_IDLE) && !ref_need;
  wire can_page   = (state == S_OPEN) && wait_done && !ref_need
                    && same_row && (ras_time < WAIT_W'(RASP_LIMIT));
  wire accept     = i_req_valid && o_req_ready;
  wire next_wr    = accept ? i_req_write : op_wr;
  wire tick       = (tick_cnt == 10'(REF_TICK_CYC - 1));
  wire ref_done   = (state == S_REF_RAS) && wait_done;
  wire power_done = (state == S_POWER) && wait_done;
  wire rd_capture = (state == S_CAS) && wait_done && !op_wr;
  wire fifo_pop   = o_rd_valid && i_rd_ready;
  wire ref_late   = (ref_pend == 3'(REF_LATE_MAX));

  assign o_req_ready = (can_start || can_page) && fifo_room;
  assign o_rd_valid  = (fifo_cnt != 2'h0);
  assign o_rd_data   = fifo_mem[fifo_rp];
  assign o_init_done = (state != S_POWER);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_wait  = wait_done ? '0 : wait_cnt - 1'b1;
    case (state)
      S_POWER: begin
        if (wait_done) next_state = S_IDLE;
      end
      S_IDLE: begin
        if (ref_need) begin
          next_state = S_REF_CAS;
          next_wait  = WAIT_W'(CSR_CYC - 1);
        end else if (accept) begin
          next_state = S_RAS;
        end
      end
      S_RAS: next_state = S_COL;
      S_COL: begin
        next_state = S_CAS;
        next_wait  = op_wr ? WAIT_W'(WR_CAS_CYC - 1)
                           : WAIT_W'(RD_CAS_CYC - 1);
      end
      S_CAS: begin
        if (wait_done) begin
          next_state = S_OPEN;
          next_wait  = WAIT_W'(CP_CYC - 1);
        end
      end
      S_OPEN: begin
        if (wait_done) begin
          if (accept) begin
            next_state = S_COL;
          end else if (ref_need || i_req_valid
                       || ras_time >= WAIT_W'(RASP_LIMIT)) begin
            next_state = S_PRE;
            next_wait  = WAIT_W'(RP_CYC - 1);
          end
        end
      end
      S_PRE: begin
        if (wait_done) next_state = S_IDLE;
      end
      S_REF_CAS: begin
        if (wait_done) begin
          next_state = S_REF_RAS;
          next_wait  = WAIT_W'(RAS_CYC - 1);
        end
      end
      S_REF_RAS: begin
        if (wait_done) begin
          next_state = S_PRE;
          next_wait  = WAIT_W'(RP_CYC - 1);
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Next pin values, registered below
  // ---------------------------------------------------------------
  wire ras_low_n = (next_state == S_RAS) || (next_state == S_COL)
                   || (next_state == S_CAS) || (next_state == S_OPEN)
                   || (next_state == S_REF_RAS);
  wire cas_low_n = (next_state == S_CAS) || (next_state == S_REF_CAS)
                   || (next_state == S_REF_RAS);
  wire col_phase = (next_state == S_COL) || (next_state == S_CAS);
  wire [ADDR_W-1:0] next_addr = accept ? i_req_addr : addr_r;
  wire [ROW_W-1:0]  row_half  = next_addr[ADDR_W-1:ROW_W];
  wire [ROW_W-1:0]  col_half  = next_addr[ROW_W-1:0];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state    <= S_POWER;
      wait_cnt <= WAIT_W'(POWER_WAIT - 1);
    end else begin
      state    <= next_state;
      wait_cnt <= next_wait;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_row_strobe_n     <= 1'b1;
      o_col_strobe_n     <= 1'b1;
      o_write_strobe_n   <= 1'b1;
      o_out_gate_n       <= 1'b1;
      o_nibble_data_oe_n <= 1'b1;
    end else begin
      o_row_strobe_n     <= !ras_low_n;
      o_col_strobe_n     <= !cas_low_n;
      o_write_strobe_n   <= !(next_wr && col_phase);
      o_out_gate_n       <= !(!next_wr && next_state == S_CAS);
      o_nibble_data_oe_n <= !(next_wr && col_phase);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_mux_address_pins <= '0;
      o_nibble_data_pins <= '0;
      addr_r             <= '0;
      op_wr              <= 1'b0;
    end else begin
      if (next_state == S_RAS) o_mux_address_pins <= row_half;
      if (col_phase) o_mux_address_pins <= col_half;
      if (accept) begin
        addr_r             <= i_req_addr;
        op_wr              <= i_req_write;
        o_nibble_data_pins <= i_req_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Refresh budget and wake-up
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tick_cnt  <= '0;
      ref_pend  <= '0;
      wake_left <= '0;
      ras_time  <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      if (power_done || ref_late) begin
        wake_left <= 4'(WAKE_CYCLES);
        ref_pend  <= '0;
      end else if (ref_done && wake_left != '0) begin
        wake_left <= wake_left - 1'b1;
        ref_pend  <= ref_pend + 3'(tick);
      end else if (state != S_POWER) begin
        ref_pend <= ref_pend + 3'(tick) - 3'(ref_done);
      end
      if (next_state == S_RAS) ras_time <= '0;
      else if (ras_time != '1) ras_time <= ras_time + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Read data: pin sync and two-entry buffer
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    din_s1 <= i_nibble_data_pins;
    din_s2 <= din_s1;
    if (rd_capture) fifo_mem[fifo_wp] <= din_s2;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      fifo_wp  <= 1'b0;
      fifo_rp  <= 1'b0;
      fifo_cnt <= '0;
    end else begin
      if (rd_capture) fifo_wp <= !fifo_wp;
      if (fifo_pop) fifo_rp <= !fifo_rp;
      fifo_cnt <= fifo_cnt + 2'(rd_capture) - 2'(fifo_pop);
    end
  end

endmodule : edopc_ctrl

/* File: dv/edopc_ctrl_sva.sv */
// Pin protocol checker for the page-mode memory controller
`timescale 1ns/1ps

module edopc_ctrl_sva
  import edopc_pkg::*;
(
  // Clock and reset
  input wire logic             i_ref_clk,
  input wire logic             i_rst,
  // Watched outputs
  input wire logic             o_req_ready,
  input wire logic             o_init_done,
  input wire logic [ROW_W-1:0] o_mux_address_pins,
  input wire logic             o_row_strobe_n,
  input wire logic             o_col_strobe_n,
  input wire logic             o_write_strobe_n,
  input wire logic             o_out_gate_n,
  input wire logic             o_nibble_data_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence ras_hold_s;
    !o_row_strobe_n [*3];
  endsequence
  sequence cbr_hold_s;
    !$past(o_col_strobe_n) ##0 !o_col_strobe_n [*3];
  endsequence
  sequence rd_cas_s;
    !o_col_strobe_n [*4];
  endsequence

  AST_RAS_MIN: assert property ($fell(o_row_strobe_n) |-> ras_hold_s)
    else $error("row strobe low too short");
  AST_PRECHARGE: assert property ($rose(o_row_strobe_n) |-> o_row_strobe_n [*2])
    else $error("row precharge too short");
  AST_CBR_SETUP: assert property (
    $fell(o_row_strobe_n) && !o_col_strobe_n |-> cbr_hold_s)
    else $error("refresh column strobe setup broken");
  AST_WR_DATA_FIRST: assert property (
    $fell(o_col_strobe_n) && !o_write_strobe_n |-> !o_nibble_data_oe_n
    && !$past(o_nibble_data_oe_n) && !$past(o_write_strobe_n))
    else $error("write data or strobe late");
  AST_READ_FLOAT: assert property (
    !o_out_gate_n |-> o_nibble_data_oe_n && o_write_strobe_n)
    else $error("data driven during read");
  AST_IDLE_FLOAT: assert property (
    o_row_strobe_n && o_col_strobe_n |-> o_nibble_data_oe_n)
    else $error("data driven in standby");
  AST_COL_ADDR: assert property (
    $fell(o_col_strobe_n) && !o_row_strobe_n |-> $stable(o_mux_address_pins))
    else $error("column address not set up");
  AST_READ_CAS: assert property (
    $fell(o_col_strobe_n) && o_write_strobe_n && !o_row_strobe_n |-> rd_cas_s)
    else $error("read column strobe too short");
  AST_READY_INIT: assert property (o_req_ready |-> o_init_done)
    else $error("request taken before power wait");
endmodule : edopc_ctrl_sva

bind edopc_ctrl edopc_ctrl_sva u_sva (
  .i_ref_clk, .i_rst, .o_req_ready, .o_init_done, .o_mux_address_pins,
  .o_row_strobe_n, .o_col_strobe_n, .o_write_strobe_n, .o_out_gate_n,
  .o_nibble_data_oe_n
);

/* File: dv/edopc_mem_model.sv */
// Behavioural page-mode memory on the controller's far side
`timescale 1ns/1ps

module edopc_mem_model
  import edopc_pkg::*;
(
  // Strobes and address
  input wire logic              i_row_strobe_n,
  input wire logic              i_col_strobe_n,
  input wire logic              i_write_strobe_n,
  input wire logic              i_out_gate_n,
  input wire logic [ROW_W-1:0]  i_mux_address_pins,
  // Data
  input wire logic [DATA_W-1:0] i_nibble_data_pins,
  output logic     [DATA_W-1:0] o_nibble_data_pins,
  output logic                  o_drive
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ROW_W-1:0]  row = '0;
  logic [ROW_W-1:0]  ref_row = '0;
  logic              refr = 1'b0;
  logic              rd_on = 1'b0;
  logic [ADDR_W-1:0] a;

  // Row latch within hold time, or refresh
  always @(negedge i_row_strobe_n) begin
    #1;
    refr = !i_col_strobe_n;
    if (refr) ref_row = ref_row + 1'b1;
    else row = i_mux_address_pins;
  end

  always @(negedge i_col_strobe_n) begin
    rd_on = 1'b0;
    a = {row, i_mux_address_pins};
    if (!i_row_strobe_n && !refr && !i_write_strobe_n)
      mem[a] = i_nibble_data_pins;
    else if (!i_row_strobe_n && !refr) begin
      o_nibble_data_pins = mem.exists(a) ? ~mem[a] : 4'hf;
      rd_on = 1'b1;
      o_nibble_data_pins <= #(T_CAC_NS) ~o_nibble_data_pins;
    end
  end

  always @(posedge i_row_strobe_n or posedge i_col_strobe_n)
    if (i_row_strobe_n && i_col_strobe_n) rd_on = 1'b0;

  assign o_drive = rd_on && !i_out_gate_n && i_write_strobe_n;
endmodule : edopc_mem_model

/* File: dv/edopc_ctrl_tb.sv */
// Self-checking bench for the page-mode memory controller
`timescale 1ns/1ps

module edopc_ctrl_tb
  import edopc_pkg::*;
;
  localparam int PW = 20;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_req_valid = 1'b0;
  logic i_req_write = 1'b0, i_rd_ready = 1'b0, rd_stall = 1'b1;
  logic [ADDR_W-1:0] i_req_addr = '0;
  logic [DATA_W-1:0] i_req_wdata = '0, o_rd_data, c_dq, m_dq, dq_last = '0;
  logic [ROW_W-1:0] o_mux_address_pins;
  logic o_req_ready, o_rd_valid, o_init_done, o_row_strobe_n, o_col_strobe_n;
  logic o_write_strobe_n, o_out_gate_n, o_nibble_data_oe_n, m_drive;
  wire [DATA_W-1:0] dq = !o_nibble_data_oe_n ? c_dq :
                         (m_drive ? m_dq : ~dq_last);
  int bad_count = 0, checked = 0, cbr_count = 0, cyc = 0;
  logic [31:0] seed = 32'h310c3580;
  logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] exp_q [$];

  edopc_ctrl #(.POWER_WAIT(PW)) u_edopc_ctrl (
    .i_ref_clk, .i_rst, .i_req_valid, .o_req_ready, .i_req_write,
    .i_req_addr, .i_req_wdata, .o_rd_valid, .i_rd_ready, .o_rd_data,
    .o_init_done, .o_mux_address_pins, .o_row_strobe_n, .o_col_strobe_n,
    .o_write_strobe_n, .o_out_gate_n, .i_nibble_data_pins(dq),
    .o_nibble_data_pins(c_dq), .o_nibble_data_oe_n);
  edopc_mem_model u_edopc_mem_model (
    .i_row_strobe_n(o_row_strobe_n), .i_col_strobe_n(o_col_strobe_n),
    .i_write_strobe_n(o_write_strobe_n), .i_out_gate_n(o_out_gate_n),
    .i_mux_address_pins(o_mux_address_pins), .i_nibble_data_pins(dq),
    .o_nibble_data_pins(m_dq), .o_drive(m_drive));

  // ---------------------------------------------------------------
  // Clock, random stream and monitors
  // ---------------------------------------------------------------
  initial forever #(CLK_NS / 2.0) i_ref_clk = ~i_ref_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  always @(posedge i_ref_clk) begin
    dq_last <= dq;
    cyc++;
    #1;
    seed = lfsr(seed);
    i_rd_ready = !rd_stall && seed[20];
  end

  always @(negedge o_row_strobe_n) if (o_col_strobe_n === 1'b0) cbr_count++;

  always @(negedge i_ref_clk)
    if (o_rd_valid === 1'b1 && i_rd_ready === 1'b1) begin
      if (exp_q.size() == 0) cmp_bit("rd_extra", 1'b0, 1'b1);
      else cmp_nib("rd_data", exp_q.pop_front(), o_rd_data);
    end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic cmp_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_nib(input string n, input logic [3:0] e,
                         input logic [3:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : cmp_nib

  task automatic do_req(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    #1;
    i_req_valid = 1'b1;
    i_req_write = w;
    i_req_addr = a;
    i_req_wdata = d;
    @(negedge i_ref_clk);
    while (o_req_ready !== 1'b1 && n < 5000) begin
      n++;
      @(negedge i_ref_clk);
    end
    if (n == 5000) bad_count++;
    @(posedge i_ref_clk);
    #1;
    i_req_valid = 1'b0;
    if (w) ref_mem[a] = d;
    else exp_q.push_back(ref_mem.exists(a) ? ref_mem[a] : 4'h0);
  endtask : do_req

  task automatic drain();
    repeat (300) if (exp_q.size() != 0) @(negedge i_ref_clk);
  endtask : drain

  task automatic wrap_up();
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    n = 0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    @(negedge i_ref_clk);
    cmp_bit("row_strobe_n", 1'b1, o_row_strobe_n);
    cmp_bit("req_ready", 1'b0, o_req_ready);
    cmp_bit("rd_valid", 1'b0, o_rd_valid);
    while (o_init_done !== 1'b1 && n < 500) begin
      n++;
      @(negedge i_ref_clk);
    end
    cmp_bit("power_wait", 1'b1, n >= PW - 1 && n <= PW + 1);
    rd_stall = 1'b0;
    for (int i = 0; i < 80; i++) begin
      if (i == 40) repeat (1400) @(posedge i_ref_clk);
      do_req(seed[2], {8'h00, seed[1:0], 6'h00, seed[13:10]}, seed[9:6]);
      if (i == 0) cmp_bit("wake_up", 1'b1, cbr_count >= 8);
    end
    drain();
    rd_stall = 1'b1;
    repeat (2) do_req(1'b0, 20'h00005, 4'h0);
    repeat (20) @(negedge i_ref_clk);
    cmp_bit("full_ready", 1'b0, o_req_ready);
    rd_stall = 1'b0;
    drain();
    cmp_bit("rd_left", 1'b1, exp_q.size() == 0);
    cmp_bit("refresh", 1'b1, cbr_count >= 7 + cyc / REF_TICK_CYC);
    wrap_up();
  end

  initial begin
    #(CLK_NS * 20000);
    bad_count++;
    wrap_up();
  end
endmodule : edopc_ctrl_tb
